// ==== bench/osc_model.sv ====
// oscillator model: fast and slow RC levels, crystal with start-up count
`timescale 1ns/1ps
module osc_model #(
  parameter int STABLE_BIT = 13
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic fastEn,
  input  wire logic slowEn,
  input  wire logic xtalEn,
  output logic      fastLvl,
  output logic      slowLvl,
  output logic      xtalLvl,
  output logic      xtalStable
);
  logic [15:0] cnt;
  logic [15:0] xtalCnt;
  // free-running counter, its bits serve as oscillator levels
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  // crystal cycles counted from zero while enabled
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xtalCnt <= 16'h0000;
    end else if (!xtalEn) begin
      xtalCnt <= 16'h0000; // restart the count whenever stopped
    end else if (cnt[2:0] == 3'h3) begin
      xtalCnt <= xtalCnt + 16'h0001;
    end
  end
  // a disabled source sits low
  assign fastLvl    = fastEn & cnt[1];
  assign slowLvl    = slowEn & cnt[4];
  assign xtalLvl    = xtalEn & cnt[2];
  assign xtalStable = xtalCnt[STABLE_BIT];
endmodule : osc_model

// ==== bench/tb.sv ====
// testbench: register traffic, source switching, hang and reset checks
`timescale 1ns/1ps
module tb;
  logic        ref_clk   = 1'b0;
  logic        rstn      = 1'b0;
  logic [9:0]  address   = 10'h000;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        fastLvl;
  logic        slowLvl;
  logic        xtalLvl;
  logic        xtalStable;
  logic        xtalEn;
  logic        fastEn;
  logic        slowEn;
  logic        sysClk;
  logic [1:0]  drive;
  logic [63:0] expQ[$];
  logic [63:0] e;
  logic [31:0] rd;
  logic [7:0]  codes[13] = '{8'h14, 8'hf4, 8'h34, 8'hb4, 8'he4,
                             8'ha6, 8'hb0, 8'hb4, 8'h3c, 8'h1c,
                             8'h7c, 8'hf4, 8'he4};
  logic [1:0]  srcs[13]  = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1,
                             2'h2, 2'h2, 2'h2, 2'h0, 2'h0,
                             2'h0, 2'h1, 2'h1};
  int          n_errors  = 0;
  int          cmp_count = 0;

  clk_source_switch dut (.ref_clk(ref_clk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .fastRcIn(fastLvl), .slowRcIn(slowLvl),
    .crystalOscIn(xtalLvl), .crystalOscEnable(xtalEn), .crystalDrive(drive),
    .fastRcEnable(fastEn), .slowRcEnable(slowEn), .sysClk(sysClk));
  osc_model #(.STABLE_BIT(4)) osc (.ref_clk(ref_clk), .rstn(rstn),
    .fastEn(fastEn), .slowEn(slowEn), .xtalEn(xtalEn), .fastLvl(fastLvl),
    .slowLvl(slowLvl), .xtalLvl(xtalLvl), .xtalStable(xtalStable));

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // compares one value, counts and reports
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one Avalon transfer; a zero mask marks an unchecked poll
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [7:0] d, input logic [31:0] m,
                     input logic [31:0] x);
    int i;
    @(posedge ref_clk);
    write     <= wr;
    read      <= !wr;
    address   <= a;
    writedata <= {24'h000000, d};
    if (!wr) expQ.push_back({m, x});
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      test_done();
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask : wr

  task automatic rdc(input logic [9:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    bus(1'b0, a, 8'h00, m, x);
  endtask : rdc

  // polls status until no switch is in progress, then compares it
  task automatic settle(input logic [7:0] x);
    int i;
    for (i = 0; i < 60; i++) begin
      bus(1'b0, 10'h030, 8'h00, 32'h0, 32'h0);
      if (rd[2] === 1'b0) break;
    end
    check("status", {24'h0, x}, rd);
  endtask : settle

  // takes the oldest note at each completed read
  always @(posedge ref_clk) begin
    if (read && waitrequest === 1'b0 && expQ.size() > 0) begin
      e = expQ.pop_front();
      if (e[63:32] != 32'h0) check("readdata", e[31:0], readdata & e[63:32]);
    end
  end

  // clock source
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // main sequence
  initial begin
    int i;
    int n;
    logic p;
    logic [7:0] d;
    n = $urandom(22369);
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(10'h02c, 32'hff, 32'h34);
    rdc(10'h028, 32'hff, 32'h00);
    check("fastEn", 32'h1, {31'h0, fastEn});
    check("slowEn", 32'h1, {31'h0, slowEn});
    // unmapped and unaligned places read zero, writes ignored
    wr(10'h03c, 8'h5a);
    rdc(10'h03c, 32'hffffffff, 32'h0);
    rdc(10'h029, 32'hffffffff, 32'h0);
    // crystal control: off, then each drive strength
    for (i = 0; i < 4; i++) begin
      d = {i != 0, i[1:0], 5'($urandom)};
      wr(10'h028, d);
      rdc(10'h028, 32'hff, {24'h0, d});
      check("xtalEn", {31'h0, d[7]}, {31'h0, xtalEn});
      check("drive", {30'h0, d[6:5]}, {30'h0, drive});
    end
    // crystal must be stable before it is selected
    for (i = 0; i < 400 && xtalStable !== 1'b1; i++) @(posedge ref_clk);
    check("xtalStable", 32'h1, {31'h0, xtalStable});
    // every select code; the running source stays on
    for (i = 0; i < 13; i++) begin
      wr(10'h02c, codes[i]);
      settle({6'h0, srcs[i]});
      check("fastEn", {31'h0, codes[i][4]}, {31'h0, fastEn});
      check("slowEn", {31'h0, codes[i][2]}, {31'h0, slowEn});
    end
    // switch and stop the running slow source at once
    wr(10'h02c, 8'h30);
    repeat (20) @(posedge ref_clk);
    rdc(10'h030, 32'h8, 32'h8);
    check("sysClk", 32'h0, {31'h0, sysClk});
    // crystal off ahead of a power-down, then a reset in mid-run
    wr(10'h028, 8'h00);
    rdc(10'h028, 32'hff, 32'h00);
    check("xtalEn", 32'h0, {31'h0, xtalEn});
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(10'h030, 32'hff, 32'h00);
    // fast RC halved: level period 8 cycles
    n = 0;
    p = sysClk;
    repeat (80) begin
      @(posedge ref_clk);
      if (sysClk === 1'b1 && p === 1'b0) n++;
      p = sysClk;
    end
    check("sysClk rises", 32'h1, {31'h0, n >= 9 && n <= 11});
    test_done();
  end
endmodule : tb

// ==== hdl/clk_source_switch.sv ====
// clock source switch: oscillator enables, select register, clock mux
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
module clk_source_switch #(
  parameter int ADDR_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              fastRcIn,
  input  wire logic              slowRcIn,
  input  wire logic              crystalOscIn,
  output logic                   crystalOscEnable,
  output logic [1:0]             crystalDrive,
  output logic                   fastRcEnable,
  output logic                   slowRcEnable,
  output logic                   sysClk
);
  clk_switch_pkg::switch_state_s st;
  clk_switch_pkg::switch_state_s nx;

  logic                     fastDivLevel;
  logic                     curLevel;
  logic                     reqAct;
  logic                     hitXtal;
  logic                     hitSel;
  logic                     hitStat;
  logic                     wrXtal;
  logic                     wrSel;
  logic [3:0]               modeCode;
  logic                     newValid;
  clk_switch_pkg::src_e     newSrc;
  logic [2:0]               newLog2;
  logic                     hazard;
  logic                     startSw;
  logic [1:0]               wdDrive;
  logic                     wdXtalEn;
  logic                     wdFastEn;
  logic                     wdSlowEn;

  // fast RC divider, fed the next ratio so a swap sees the new level at once
  rc_clock_divider u_fast_div (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .oscLevel  (fastRcIn),
    .ratioLog2 (nx.fastLog2),
    .divLevel  (fastDivLevel)
  );

  // write data fields
  assign wdDrive  = writedata[clk_switch_pkg::DRIVE_HI_BIT:
                              clk_switch_pkg::DRIVE_LO_BIT];
  assign wdXtalEn = writedata[clk_switch_pkg::XTAL_EN_BIT];
  assign wdFastEn = writedata[clk_switch_pkg::FAST_EN_BIT];
  assign wdSlowEn = writedata[clk_switch_pkg::SLOW_EN_BIT];
  assign modeCode = {writedata[clk_switch_pkg::MODE_HI_BIT:
                               clk_switch_pkg::MODE_LO_BIT],
                     writedata[clk_switch_pkg::MODE_DIV_BIT]};

  // bus decode, word aligned addresses only
  assign reqAct  = read | write;
  assign hitXtal = address[1:0] == 2'h0 && address[ADDR_W-1:2] ==
                   (ADDR_W-2)'(clk_switch_pkg::XTAL_CTRL_INDEX);
  assign hitSel  = address[1:0] == 2'h0 && address[ADDR_W-1:2] ==
                   (ADDR_W-2)'(clk_switch_pkg::CLK_SEL_INDEX);
  assign hitStat = address[1:0] == 2'h0 && address[ADDR_W-1:2] ==
                   (ADDR_W-2)'(clk_switch_pkg::STATUS_INDEX);
  assign wrXtal  = write && !st.waitReq && hitXtal;
  assign wrSel   = write && !st.waitReq && hitSel;

  // next state of the whole block
  always_comb begin
    nx       = st;
    newValid = 1'b1;
    newSrc   = clk_switch_pkg::SRC_FAST;
    newLog2  = st.fastLog2;
    curLevel = fastDivLevel;
    hazard   = 1'b0;
    startSw  = 1'b0;

    // level of the source now driving the clock
    case (st.src)
      clk_switch_pkg::SRC_SLOW: curLevel = slowRcIn;
      clk_switch_pkg::SRC_XTAL: curLevel = crystalOscIn;
      default:                  curLevel = fastDivLevel;
    endcase

    // decode of the source select code
    case (modeCode)
      clk_switch_pkg::MODE_FAST_DIV2:  newLog2 = clk_switch_pkg::LOG2_DIV2;
      clk_switch_pkg::MODE_FAST_DIV4:  newLog2 = clk_switch_pkg::LOG2_DIV4;
      clk_switch_pkg::MODE_FAST_DIV8:  newLog2 = clk_switch_pkg::LOG2_DIV8;
      clk_switch_pkg::MODE_FAST_DIV16: newLog2 = clk_switch_pkg::LOG2_DIV16;
      clk_switch_pkg::MODE_FAST_DIV32: newLog2 = clk_switch_pkg::LOG2_DIV32;
      clk_switch_pkg::MODE_SLOW:       newSrc  = clk_switch_pkg::SRC_SLOW;
      clk_switch_pkg::MODE_XTAL:       newSrc  = clk_switch_pkg::SRC_XTAL;
      default:                         newValid = 1'b0;
    endcase

    // moving away from an oscillator that this same write stops
    hazard = wrSel && newValid && newSrc != st.src &&
             ((st.src == clk_switch_pkg::SRC_FAST && !wdFastEn) ||
              (st.src == clk_switch_pkg::SRC_SLOW && !wdSlowEn));
    startSw = wrSel && newValid && !hazard &&
              st.sw != clk_switch_pkg::SW_HUNG &&
              {newSrc, newLog2} != {st.src, st.fastLog2};

    // glitch free change over: old low, swap, new low, follow
    case (st.sw)
      clk_switch_pkg::SW_RUN: begin
        nx.sysClk = curLevel;
      end
      clk_switch_pkg::SW_OLD_LOW: begin
        nx.sysClk = st.sysClk & curLevel; // may fall, never rise
        if (!curLevel) begin
          nx.src      = st.tgtSrc;
          nx.fastLog2 = st.tgtLog2;
          nx.sysClk   = 1'b0;
          nx.sw       = clk_switch_pkg::SW_NEW_LOW;
        end
      end
      clk_switch_pkg::SW_NEW_LOW: begin
        nx.sysClk = 1'b0;
        if (!curLevel) begin
          nx.sw = clk_switch_pkg::SW_RUN;
        end
      end
      default: begin
        nx.sysClk = 1'b0; // clock frozen until reset
      end
    endcase

    // bus handshake: one wait cycle, then the answer
    nx.waitReq = !(reqAct && st.waitReq);
    if (read && st.waitReq) begin
      if (hitXtal) begin
        nx.rdata = {24'h000000, st.xtalCtrl};
      end else if (hitSel) begin
        nx.rdata = {24'h000000, st.clkSel};
      end else if (hitStat) begin
        nx.rdata = 32'h0000_0000;
        nx.rdata[1:0] = st.src;
        nx.rdata[clk_switch_pkg::STAT_BUSY_BIT] =
          st.sw == clk_switch_pkg::SW_OLD_LOW ||
          st.sw == clk_switch_pkg::SW_NEW_LOW;
        nx.rdata[clk_switch_pkg::STAT_HUNG_BIT] =
          st.sw == clk_switch_pkg::SW_HUNG;
      end else begin
        nx.rdata = 32'h0000_0000;
      end
    end

    // register writes
    if (wrXtal) begin
      nx.xtalCtrl = writedata[7:0];
    end
    if (wrSel) begin
      nx.clkSel = writedata[7:0];
      if (newValid) begin
        nx.tgtSrc  = newSrc;
        nx.tgtLog2 = newLog2;
      end
    end
    if (hazard) begin
      nx.sw     = clk_switch_pkg::SW_HUNG;
      nx.sysClk = 1'b0;
    end else if (startSw) begin
      nx.sw = clk_switch_pkg::SW_OLD_LOW;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= clk_switch_pkg::SWITCH_RESET;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from the state register
  assign readdata         = st.rdata;
  assign waitrequest      = st.waitReq;
  assign crystalOscEnable = st.xtalCtrl[clk_switch_pkg::XTAL_EN_BIT];
  assign crystalDrive     = st.xtalCtrl[clk_switch_pkg::DRIVE_HI_BIT:
                                        clk_switch_pkg::DRIVE_LO_BIT];
  assign fastRcEnable     = st.clkSel[clk_switch_pkg::FAST_EN_BIT];
  assign slowRcEnable     = st.clkSel[clk_switch_pkg::SLOW_EN_BIT];
  assign sysClk           = st.sysClk;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // crystal enable follows the written bit
  property p_xtal_enable;
    wrXtal |=> crystalOscEnable == $past(wdXtalEn);
  endproperty
  a_xtal_enable: assert property (p_xtal_enable)
    else $error("crystal enable does not follow write");

  // drive strength follows the written field and holds
  property p_xtal_drive;
    wrXtal ##1 !wrXtal |-> crystalDrive == $past(wdDrive, 2);
  endproperty
  a_xtal_drive: assert property (p_xtal_drive)
    else $error("crystal drive does not follow write");

  // answer one cycle after the request, switch starts at once
  property p_immediate;
    (reqAct && waitrequest |=> !waitrequest) and
    (startSw |=> st.sw == clk_switch_pkg::SW_OLD_LOW);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("select write not taken at once");

  // hazardous write freezes the clock
  sequence s_frozen;
    (st.sw == clk_switch_pkg::SW_HUNG && !sysClk)[*4];
  endsequence
  property p_hang;
    hazard |=> s_frozen;
  endproperty
  a_hang: assert property (p_hang)
    else $error("hazardous switch did not hang");

  // 0x34: fast RC over two, slow RC kept
  property p_code34;
    wrSel && writedata[7:0] == 8'h34 |=>
      st.tgtSrc == clk_switch_pkg::SRC_FAST &&
      st.tgtLog2 == clk_switch_pkg::LOG2_DIV2 && slowRcEnable;
  endproperty
  a_code34: assert property (p_code34)
    else $error("0x34 not decoded as fast over two");

  // 0xf4: slow RC, fast RC kept
  property p_codef4;
    wrSel && writedata[7:0] == 8'hf4 |=>
      st.tgtSrc == clk_switch_pkg::SRC_SLOW && fastRcEnable;
  endproperty
  a_codef4: assert property (p_codef4)
    else $error("0xf4 not decoded as slow RC");

  // 0xb0, 0xb4 and 0xa6: crystal
  property p_code_xtal;
    wrSel && (writedata[7:0] == 8'hb0 || writedata[7:0] == 8'hb4 ||
              writedata[7:0] == 8'ha6) |=>
      st.tgtSrc == clk_switch_pkg::SRC_XTAL;
  endproperty
  a_code_xtal: assert property (p_code_xtal)
    else $error("crystal code not decoded");

  // 0x14: fast RC over four, slow RC kept
  property p_code14;
    wrSel && writedata[7:0] == 8'h14 |=>
      st.tgtLog2 == clk_switch_pkg::LOG2_DIV4 &&
      st.tgtSrc == clk_switch_pkg::SRC_FAST && slowRcEnable;
  endproperty
  a_code14: assert property (p_code14)
    else $error("0x14 not decoded as fast over four");

  // RC enables follow their select bits
  property p_rc_enables;
    wrSel |=> fastRcEnable == $past(wdFastEn) &&
              slowRcEnable == $past(wdSlowEn);
  endproperty
  a_rc_enables: assert property (p_rc_enables)
    else $error("RC enable does not follow select bit");

  // both RC oscillators on after reset
  property p_boot;
    $past(rstn) == 1'b0 |-> fastRcEnable && slowRcEnable;
  endproperty
  a_boot: assert property (p_boot)
    else $error("RC oscillators not enabled after reset");

  // clock rises only while following a settled source
  property p_no_runt;
    $rose(sysClk) |-> $past(st.sw) == clk_switch_pkg::SW_RUN;
  endproperty
  a_no_runt: assert property (p_no_runt)
    else $error("clock rose during a change over");
endmodule : clk_source_switch

// ==== hdl/clk_switch_pkg.sv ====
// package: register map, select codes and state types of the clock switch
// Operation
// - crystal control bit 7 switches crystal oscillator
// - bits 6:5 set crystal drive strength
// - clock select write takes effect immediately
// - switch plus disabling running oscillator hangs
// - 0x34 selects fast RC divided by two
// - 0xf4 selects slow RC, fast stays on
// - 0xb0 or 0xb4 selects crystal oscillator
// - 0x14 selects fast RC divided by four
// - 0xa6 selects crystal oscillator
// - bits 4 and 2 enable fast, slow RC
// - both RC oscillators enabled after reset
package clk_switch_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] XTAL_CTRL_INDEX = 8'h0a;
  localparam logic [7:0] CLK_SEL_INDEX   = 8'h0b;
  localparam logic [7:0] STATUS_INDEX    = 8'h0c;
  // reset values
  localparam logic [7:0] XTAL_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_SEL_RESET   = 8'h34;
  // field positions
  localparam int XTAL_EN_BIT   = 7;
  localparam int DRIVE_HI_BIT  = 6;
  localparam int DRIVE_LO_BIT  = 5;
  localparam int FAST_EN_BIT   = 4;
  localparam int SLOW_EN_BIT   = 2;
  localparam int MODE_HI_BIT   = 7;
  localparam int MODE_LO_BIT   = 5;
  localparam int MODE_DIV_BIT  = 3;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_HUNG_BIT = 3;
  // source select codes, bits 7:5 then bit 3
  localparam logic [3:0] MODE_FAST_DIV4  = 4'h0;
  localparam logic [3:0] MODE_FAST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_FAST_DIV2  = 4'h2;
  localparam logic [3:0] MODE_FAST_DIV8  = 4'h3;
  localparam logic [3:0] MODE_FAST_DIV32 = 4'h7;
  localparam logic [3:0] MODE_XTAL       = 4'ha;
  localparam logic [3:0] MODE_SLOW       = 4'he;
  // fast RC divide ratios as powers of two
  localparam logic [2:0] LOG2_DIV2  = 3'h1;
  localparam logic [2:0] LOG2_DIV4  = 3'h2;
  localparam logic [2:0] LOG2_DIV8  = 3'h3;
  localparam logic [2:0] LOG2_DIV16 = 3'h4;
  localparam logic [2:0] LOG2_DIV32 = 3'h5;

  typedef enum logic [1:0] {SRC_FAST, SRC_SLOW, SRC_XTAL} src_e;
  typedef enum logic [1:0] {SW_RUN, SW_OLD_LOW, SW_NEW_LOW, SW_HUNG} sw_e;

  typedef struct packed {
    logic [7:0]  xtalCtrl;
    logic [7:0]  clkSel;
    src_e        src;
    logic [2:0]  fastLog2;
    src_e        tgtSrc;
    logic [2:0]  tgtLog2;
    sw_e         sw;
    logic        sysClk;
    logic        waitReq;
    logic [31:0] rdata;
  } switch_state_s;

  typedef struct packed {
    logic       prevLevel;
    logic [4:0] cnt;
    logic       divLevel;
  } div_state_s;

  localparam switch_state_s SWITCH_RESET = '{
    xtalCtrl: XTAL_CTRL_RESET, clkSel: CLK_SEL_RESET, src: SRC_FAST,
    fastLog2: LOG2_DIV2, tgtSrc: SRC_FAST, tgtLog2: LOG2_DIV2,
    sw: SW_RUN, sysClk: 1'b0, waitReq: 1'b1, rdata: 32'h0000_0000};
  localparam div_state_s DIV_RESET = '{
    prevLevel: 1'b0, cnt: 5'h00, divLevel: 1'b0};
endpackage : clk_switch_pkg

// ==== hdl/rc_clock_divider.sv ====
// fast RC divider: divides a sampled oscillator level by a power of two
`timescale 1ns/1ps
module rc_clock_divider (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       oscLevel,
  input  wire logic [2:0] ratioLog2,
  output logic            divLevel
);
  clk_switch_pkg::div_state_s st;
  clk_switch_pkg::div_state_s nx;

  // count rising edges, the chosen counter bit is the divided level
  always_comb begin
    nx = st;
    nx.prevLevel = oscLevel;
    if (oscLevel && !st.prevLevel) begin
      nx.cnt = st.cnt + 5'h01;
    end
    if (ratioLog2 == 3'h0 || ratioLog2 > 3'h5) begin
      nx.divLevel = oscLevel; // undivided
    end else begin
      nx.divLevel = nx.cnt[ratioLog2 - 3'h1];
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= clk_switch_pkg::DIV_RESET;
    end else begin
      st <= nx;
    end
  end

  assign divLevel = st.divLevel;
endmodule : rc_clock_divider
